// *** logic/pump_stage_pkg.sv ***
/*
   constants and types shared by the pump staging controller.
   assumes a 100 MHz system clock and whole-second timing.
*/
package pump_stage_pkg;

   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned TICK_S          = 1;
   localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_S;

   localparam int          VAL_W           = 16;
   localparam int          PCT_W           = 8;
   localparam int          SEC_W           = 12;
   localparam int          PUMP_W          = 3;
   localparam int          MAX_PUMPS       = 4;

   localparam logic [PCT_W-1:0] STAGE_PCT_MIN    = 8'h01;
   localparam logic [PCT_W-1:0] PCT_FULL         = 8'h64;
   localparam logic [PCT_W-1:0] OVR_PCT_MIN      = 8'h02;
   localparam logic [PCT_W-1:0] OVR_OFF          = 8'h64;
   localparam logic [PCT_W-1:0] HANDOVER_MAX     = 8'h78;
   localparam logic [PCT_W-1:0] HANDOVER_DEF     = 8'h5a;
   localparam logic [SEC_W-1:0] DELAY_MAX        = 12'hbb8;
   localparam logic [SEC_W-1:0] DELAY_DEF        = 12'h01e;
   localparam logic [SEC_W-1:0] LOCK_MAX         = 12'h12c;
   localparam logic [SEC_W-1:0] LOCK_DEF         = 12'h00a;
   localparam logic [VAL_W-1:0] SETPOINT_DEF     = 16'h0000;
   localparam logic [PCT_W-1:0] SPEED_FULL       = 8'h64;
   localparam logic [PCT_W-1:0] LOSS_PCT_PER_PMP = 8'h02;
   // edges after reset release until the band zones see real samples
   localparam logic [1:0]       WARM_DONE        = 2'h3;

   typedef enum logic [1:0]
   {
      ZONE_IN,
      ZONE_HIGH,
      ZONE_LOW
   } zone_t;

   function automatic logic [VAL_W-1:0] pct_of
   (
      input logic [VAL_W-1:0] value,
      input logic [PCT_W-1:0] pct
   );
      logic [VAL_W+PCT_W-1:0] prod;
      prod = value * pct;
      return VAL_W'(prod / PCT_FULL);
   endfunction : pct_of

   function automatic logic [PCT_W-1:0] clamp_pct
   (
      input logic [PCT_W-1:0] pct,
      input logic [PCT_W-1:0] lo,
      input logic [PCT_W-1:0] hi
   );
      return (pct < lo) ? lo : ((pct > hi) ? hi : pct);
   endfunction : clamp_pct

endpackage : pump_stage_pkg

// *** logic/band_if.sv ***
/*
   carrier between band comparator and staging core.
   assumes both ends on the same clock.
*/
`timescale 1ns/100ps
interface band_if;
   pump_stage_pkg::zone_t stage_zone;
   pump_stage_pkg::zone_t ovr_zone;
   logic                  ovr_enabled;
   logic                  tick;

   modport source
   (
      output stage_zone,
      output ovr_zone,
      output ovr_enabled,
      output tick
   );
   modport sink
   (
      input  stage_zone,
      input  ovr_zone,
      input  ovr_enabled,
      input  tick
   );
endinterface : band_if

// *** logic/band_compare.sv ***
/*
   band comparator and one-second tick generator.
   assumes feedback already synchronised; reference is scaled upstream.
*/
`timescale 1ns/100ps
module band_compare
#(
   parameter int unsigned TICK_CYCLES = pump_stage_pkg::TICK_CYCLES
)
(
   // clock and reset
   input  wire logic                              ref_clk_i,
   input  wire logic                              resetn_i,
   // values
   input  wire logic [pump_stage_pkg::VAL_W-1:0] reference_i,
   input  wire logic [pump_stage_pkg::VAL_W-1:0] feedback_i,
   input  wire logic [pump_stage_pkg::PCT_W-1:0] staging_band_pct_i,
   input  wire logic [pump_stage_pkg::PCT_W-1:0] override_band_pct_i,
   // to core
   band_if.source                                 band
);

   typedef struct packed
   {
      logic [31:0]           cnt;
      logic                  tick;
      pump_stage_pkg::zone_t sz;
      pump_stage_pkg::zone_t oz;
      logic                  oen;
   } cmp_state_t;

   cmp_state_t st;
   cmp_state_t next_st;

   logic [pump_stage_pkg::PCT_W-1:0] staging_band_pct;
   logic [pump_stage_pkg::PCT_W-1:0] override_band_pct;
   logic [pump_stage_pkg::VAL_W-1:0] shalf;
   logic [pump_stage_pkg::VAL_W-1:0] ohalf;

   always_comb
   begin
      staging_band_pct   = pump_stage_pkg::clamp_pct(staging_band_pct_i, pump_stage_pkg::STAGE_PCT_MIN,
                                        pump_stage_pkg::PCT_FULL);
      override_band_pct   = pump_stage_pkg::clamp_pct(override_band_pct_i, pump_stage_pkg::OVR_PCT_MIN,
                                        pump_stage_pkg::PCT_FULL);
      shalf = pump_stage_pkg::pct_of(reference_i, staging_band_pct);
      ohalf = pump_stage_pkg::pct_of(reference_i, override_band_pct);
      next_st = st;
      next_st.tick = 1'b0;
      if (st.cnt >= TICK_CYCLES - 1)
      begin
         next_st.cnt  = '0;
         next_st.tick = 1'b1;
      end
      else
      begin
         next_st.cnt = st.cnt + 32'h0000_0001;
      end
      // compare in 17 bits so band edges never wrap
      if ({1'b0, feedback_i} > {1'b0, reference_i} + {1'b0, shalf})
         next_st.sz = pump_stage_pkg::ZONE_HIGH;
      else if ({1'b0, feedback_i} + {1'b0, shalf} < {1'b0, reference_i})
         next_st.sz = pump_stage_pkg::ZONE_LOW;
      else
         next_st.sz = pump_stage_pkg::ZONE_IN;
      if ({1'b0, feedback_i} > {1'b0, reference_i} + {1'b0, ohalf})
         next_st.oz = pump_stage_pkg::ZONE_HIGH;
      else if ({1'b0, feedback_i} + {1'b0, ohalf} < {1'b0, reference_i})
         next_st.oz = pump_stage_pkg::ZONE_LOW;
      else
         next_st.oz = pump_stage_pkg::ZONE_IN;
      next_st.oen = (override_band_pct_i < pump_stage_pkg::OVR_OFF);
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         st <= '0;
      else
         st <= next_st;
   end

   assign band.stage_zone  = st.sz;
   assign band.ovr_zone    = st.oz;
   assign band.ovr_enabled = st.oen;
   assign band.tick        = st.tick;

   chk_tick_single: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.tick |=> !st.tick)
      else $error("tick lasted more than one cycle");

endmodule : band_compare

// *** logic/pump_staging_controller.sv ***
/*
   pump staging controller: band staging, delay timers, override with
   lockout, handover speed and fixed relay order.
   assumes configuration inputs are quasi-static and come from the same clock;
   feedback arrives from an outside converter and is synchronised here.
*/
`timescale 1ns/100ps
module pump_staging_controller
#(
   parameter int unsigned TICK_CYCLES = pump_stage_pkg::TICK_CYCLES,
   parameter int unsigned MAX_PUMPS   = pump_stage_pkg::MAX_PUMPS
)
(
   // clock and reset
   input  wire logic                              ref_clk_i,
   input  wire logic                              resetn_i,
   // measurement
   input  wire logic [pump_stage_pkg::VAL_W-1:0] feedback_i,
   // configuration
   input  wire logic [pump_stage_pkg::VAL_W-1:0] setpoint_i,
   input  wire logic [pump_stage_pkg::VAL_W-1:0] feedback_min_i,
   input  wire logic [pump_stage_pkg::VAL_W-1:0] feedback_max_i,
   input  wire logic [pump_stage_pkg::PCT_W-1:0] staging_band_pct_i,
   input  wire logic [pump_stage_pkg::PCT_W-1:0] override_band_pct_i,
   input  wire logic [pump_stage_pkg::SEC_W-1:0] stage_delay_s_i,
   input  wire logic [pump_stage_pkg::SEC_W-1:0] destage_delay_s_i,
   input  wire logic [pump_stage_pkg::SEC_W-1:0] lockout_s_i,
   input  wire logic [pump_stage_pkg::PCT_W-1:0] handover_speed_pct_i,
   input  wire logic [pump_stage_pkg::PUMP_W-1:0] pump_count_i,
   // drive status
   input  wire logic                              drive_trip_i,
   // pump and drive outputs
   output logic [MAX_PUMPS-1:0]                   pump_relay_o,
   output logic [pump_stage_pkg::PUMP_W-1:0]      pumps_on_o,
   output logic [pump_stage_pkg::PCT_W-1:0]       speed_cmd_pct_o,
   output logic                                   speed_override_o,
   output logic [pump_stage_pkg::VAL_W-1:0]       reference_o
);

   ////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0]
   {
      ST_IDLE,
      ST_SLOW,
      ST_BOOST
   } seq_t;

   typedef struct packed
   {
      logic [pump_stage_pkg::VAL_W-1:0]  fb_meta;
      logic [pump_stage_pkg::VAL_W-1:0]  fb;
      logic [pump_stage_pkg::VAL_W-1:0]  ref_v;
      seq_t                              seq;
      logic [pump_stage_pkg::SEC_W-1:0]  stage_t;
      logic [pump_stage_pkg::SEC_W-1:0]  destage_t;
      logic [pump_stage_pkg::SEC_W-1:0]  lock_t;
      logic [pump_stage_pkg::PUMP_W-1:0] on_cnt;
      logic [MAX_PUMPS-1:0]              relay;
      logic [pump_stage_pkg::PCT_W-1:0]  speed;
      logic                              spd_ovr;
      logic [1:0]                        warm;
   } ctl_state_t;

   ctl_state_t st;
   ctl_state_t next_st;

   band_if band ();

   band_compare #(.TICK_CYCLES(TICK_CYCLES)) u_band
   (
      .ref_clk_i           (ref_clk_i),
      .resetn_i            (resetn_i),
      .reference_i         (st.ref_v),
      .feedback_i          (st.fb),
      .staging_band_pct_i  (staging_band_pct_i),
      .override_band_pct_i (override_band_pct_i),
      .band                (band.source)
   );

   ////////////////////////////////////////////////////////////////////
   logic [pump_stage_pkg::VAL_W-1:0]  sp_clamped;
   logic [pump_stage_pkg::VAL_W+pump_stage_pkg::PCT_W-1:0] ref_wide;
   logic [pump_stage_pkg::PUMP_W-1:0] limit;
   logic [pump_stage_pkg::PCT_W-1:0]  handover;
   logic [pump_stage_pkg::SEC_W-1:0]  sdly;
   logic [pump_stage_pkg::SEC_W-1:0]  ddly;
   logic [pump_stage_pkg::SEC_W-1:0]  ldly;
   logic                              want_add;
   logic                              want_drop;
   logic                              ovr_ok;

   always_comb
   begin
      next_st = st;
      // two stages on the outside measurement
      next_st.fb_meta = feedback_i;
      next_st.fb      = st.fb_meta;
      // setpoint is the only reference source
      if (setpoint_i < feedback_min_i)
         sp_clamped = feedback_min_i;
      else if (setpoint_i > feedback_max_i)
         sp_clamped = feedback_max_i;
      else
         sp_clamped = setpoint_i;
      // each running pump adds a small loss allowance
      ref_wide = sp_clamped * (pump_stage_pkg::PCT_FULL
                 + pump_stage_pkg::LOSS_PCT_PER_PMP * st.on_cnt);
      next_st.ref_v = pump_stage_pkg::VAL_W'(ref_wide / pump_stage_pkg::PCT_FULL);

      limit    = (pump_count_i > pump_stage_pkg::PUMP_W'(MAX_PUMPS))
                 ? pump_stage_pkg::PUMP_W'(MAX_PUMPS) : pump_count_i;
      handover = (handover_speed_pct_i > pump_stage_pkg::HANDOVER_MAX)
                 ? pump_stage_pkg::HANDOVER_MAX : handover_speed_pct_i;
      sdly = (stage_delay_s_i > pump_stage_pkg::DELAY_MAX) ? pump_stage_pkg::DELAY_MAX : stage_delay_s_i;
      ddly = (destage_delay_s_i > pump_stage_pkg::DELAY_MAX) ? pump_stage_pkg::DELAY_MAX : destage_delay_s_i;
      ldly = (lockout_s_i > pump_stage_pkg::LOCK_MAX) ? pump_stage_pkg::LOCK_MAX : lockout_s_i;

      ovr_ok = band.ovr_enabled && (st.lock_t == '0);
      want_add  = 1'b0;
      want_drop = 1'b0;

      // delay timers, cleared on return into the band
      if (band.stage_zone == pump_stage_pkg::ZONE_LOW)
      begin
         next_st.destage_t = '0;
         if (st.stage_t >= sdly)
            want_add = 1'b1;
         else if (band.tick)
            next_st.stage_t = st.stage_t + 12'h001;
         if (ovr_ok && band.ovr_zone == pump_stage_pkg::ZONE_LOW)
            want_add = 1'b1;
      end
      else if (band.stage_zone == pump_stage_pkg::ZONE_HIGH)
      begin
         next_st.stage_t = '0;
         if (st.destage_t >= ddly)
            want_drop = 1'b1;
         else if (band.tick)
            next_st.destage_t = st.destage_t + 12'h001;
         if (ovr_ok && band.ovr_zone == pump_stage_pkg::ZONE_HIGH)
            want_drop = 1'b1;
      end
      else
      begin
         next_st.stage_t   = '0;
         next_st.destage_t = '0;
      end

      // the synchroniser wakes up at zero, which reads as a deep pressure drop;
      // with lockout clear the override would add a pump on that ghost, so
      // nothing moves until real samples have reached the band zones
      if (st.warm != pump_stage_pkg::WARM_DONE)
      begin
         next_st.warm      = st.warm + 2'h1;
         next_st.stage_t   = '0;
         next_st.destage_t = '0;
         want_add          = 1'b0;
         want_drop         = 1'b0;
      end

      if (st.lock_t != '0 && band.tick)
         next_st.lock_t = st.lock_t - 12'h001;

      // drive trip only frees the speed output; staging goes on
      next_st.spd_ovr = 1'b0;
      case (st.seq)
         ST_IDLE:
         begin
            next_st.speed = pump_stage_pkg::SPEED_FULL;
            if (want_add && st.on_cnt < limit)
            begin
               next_st.seq     = ST_SLOW;
               next_st.speed   = handover;
               next_st.spd_ovr = !drive_trip_i;
            end
            else if (want_drop && st.on_cnt != '0)
            begin
               next_st.seq     = ST_BOOST;
               next_st.speed   = pump_stage_pkg::SPEED_FULL;
               next_st.spd_ovr = !drive_trip_i;
            end
         end
         ST_SLOW:
         begin
            // relay closes one cycle after speed has dropped
            next_st.relay[st.on_cnt[1:0]] = 1'b1;
            next_st.on_cnt    = st.on_cnt + 3'h1;
            next_st.stage_t   = '0;
            next_st.destage_t = '0;
            next_st.lock_t    = ldly;
            next_st.seq       = ST_IDLE;
         end
         ST_BOOST:
         begin
            next_st.relay[2'(st.on_cnt - 3'h1)] = 1'b0;
            next_st.on_cnt    = st.on_cnt - 3'h1;
            next_st.stage_t   = '0;
            next_st.destage_t = '0;
            next_st.lock_t    = ldly;
            next_st.seq       = ST_IDLE;
         end
         default:
            next_st.seq = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         st       <= '0;
         st.speed <= pump_stage_pkg::SPEED_FULL;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign pump_relay_o     = st.relay;
   assign pumps_on_o       = st.on_cnt;
   assign speed_cmd_pct_o  = st.speed;
   assign speed_override_o = st.spd_ovr;
   assign reference_o      = st.ref_v;

   ////////////////////////////////////////////////////////////////////
   chk_in_band_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (band.stage_zone == pump_stage_pkg::ZONE_IN && st.seq == ST_IDLE) |=> $stable(st.relay))
      else $error("relays changed while feedback in band");

   chk_stage_clear: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (band.stage_zone != pump_stage_pkg::ZONE_LOW) |=> (st.stage_t == '0))
      else $error("stage timer not cleared");

   chk_destage_clear: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (band.stage_zone != pump_stage_pkg::ZONE_HIGH) |=> (st.destage_t == '0))
      else $error("destage timer not cleared");

   chk_slow_first: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (st.seq == ST_SLOW) |-> (st.speed == handover) ##1 (st.on_cnt == $past(st.on_cnt) + 3'h1))
      else $error("pump added without handover speed");

   chk_boost_drop: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (st.seq == ST_BOOST) |-> (st.speed == pump_stage_pkg::SPEED_FULL))
      else $error("destage without speed raise");

   chk_lock_load: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (st.seq == ST_SLOW || st.seq == ST_BOOST) |=> (st.lock_t == $past(ldly)))
      else $error("lockout not loaded after staging");

   chk_count_range: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      $changed(st.on_cnt) |-> (st.on_cnt - $past(st.on_cnt) == 3'h1 ||
                               $past(st.on_cnt) - st.on_cnt == 3'h1))
      else $error("pump count jumped by more than one");

   chk_relay_order: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      $rose(st.on_cnt == 3'h1) |-> (st.relay == 4'h1))
      else $error("first pump not on first relay");

   chk_count_limit: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (st.seq == ST_IDLE) |-> (st.on_cnt <= pump_stage_pkg::PUMP_W'(MAX_PUMPS)))
      else $error("pump count over maximum");

   // start-up, relay pattern and speed handover guards
   chk_warmup_idle: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (st.warm != pump_stage_pkg::WARM_DONE) |=> (st.seq == ST_IDLE))
      else $error("pump action before feedback pipe filled");

   chk_relay_fill: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.relay == (MAX_PUMPS'(1) << st.on_cnt) - MAX_PUMPS'(1))
      else $error("relays not a gap-free run from the first");

   chk_ovr_pulse: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.spd_ovr |-> (st.seq == ST_SLOW || st.seq == ST_BOOST))
      else $error("speed override outside a transition");

   chk_trip_release: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (st.seq == ST_SLOW || st.seq == ST_BOOST) |-> (st.spd_ovr == !$past(drive_trip_i)))
      else $error("speed override ignores drive trip");

   chk_speed_idle: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (st.seq == ST_IDLE && $past(st.seq) == ST_IDLE) |-> (st.speed == pump_stage_pkg::SPEED_FULL))
      else $error("speed not back to full after transition");

endmodule : pump_staging_controller

// *** dv/pump_bank_model.sv ***
/*
   far-side model: relay-switched fixed pumps and the pressure transmitter.
   assumes the bench sets the demanded pressure on the system clock.
*/
`timescale 1ns/100ps
module pump_bank_model
#(
   parameter int unsigned N = 4
)
(
   // clock
   input  wire logic                              ref_clk_i,
   // relays and demand
   input  wire logic [N-1:0]                      relay_i,
   input  wire logic [pump_stage_pkg::VAL_W-1:0]  pressure_i,
   // transmitter and pump status
   output logic      [pump_stage_pkg::VAL_W-1:0]  feedback_o,
   output logic      [pump_stage_pkg::PUMP_W-1:0] running_o
);
   // transmitter output lags the process by one sample
   always_ff @(posedge ref_clk_i)
   begin
      feedback_o <= pressure_i;
   end
   ////////////////////////////////////////////////////////////////////////
   // only a gap-free run from the lowest relay counts as running pumps
   always_comb
   begin
      running_o = '0;
      for (int i = 0; i < N; i++)
      begin
         if (relay_i[i] === 1'b1 && running_o == i)
         begin
            running_o = running_o + 3'h1;
         end
      end
   end
endmodule : pump_bank_model

// *** dv/pump_staging_controller_tb_top.sv ***
/*
   self-checking bench for the pump staging controller.
   assumes a 10-cycle tick so that seconds stay short in simulation.
*/
`timescale 1ns/100ps
module pump_staging_controller_tb_top;
   localparam int          T  = 10;
   localparam logic [15:0] SP = 16'h1000;
   logic        ref_clk_i = 1'b0;
   logic        resetn_i  = 1'b0;
   logic [15:0] pressure  = 16'h1068;
   logic [15:0] feedback;
   logic [15:0] setpoint  = SP;
   logic [15:0] fb_min    = 16'h0000;
   logic [15:0] fb_max    = 16'hffff;
   logic [7:0]  staging_band_pct       = 8'h0a;
   logic [7:0]  override_band_pct       = 8'h64;
   logic [11:0] st_dly    = 12'h002;
   logic [11:0] ds_dly    = 12'h002;
   logic [11:0] lock      = 12'h002;
   logic [7:0]  hand      = 8'h5a;
   logic [2:0]  pcount    = 3'h4;
   logic        trip      = 1'b0;
   logic [3:0]  relay;
   logic [2:0]  pumps_on;
   logic [7:0]  speed;
   logic        ovr;
   logic [15:0] refo;
   logic [2:0]  running;
   int          error_cnt = 0;
   int          checked   = 0;
   int          n_exp     = 0;
   int          d;
   int          lim;
   int          k;
   always #5 ref_clk_i = ~ref_clk_i;
   pump_staging_controller #(.TICK_CYCLES(T), .MAX_PUMPS(4)) i_pump_staging_controller
   (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .feedback_i(feedback), .setpoint_i(setpoint),
      .feedback_min_i(fb_min), .feedback_max_i(fb_max), .staging_band_pct_i(staging_band_pct),
      .override_band_pct_i(override_band_pct), .stage_delay_s_i(st_dly), .destage_delay_s_i(ds_dly),
      .lockout_s_i(lock), .handover_speed_pct_i(hand), .pump_count_i(pcount), .drive_trip_i(trip),
      .pump_relay_o(relay), .pumps_on_o(pumps_on), .speed_cmd_pct_o(speed),
      .speed_override_o(ovr), .reference_o(refo)
   );
   pump_bank_model #(.N(4)) i_pump_bank_model
   (
      .ref_clk_i(ref_clk_i), .relay_i(relay), .pressure_i(pressure), .feedback_o(feedback),
      .running_o(running)
   );
   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : check
   function automatic logic [31:0] ref_exp(input int n);
      return SP * (100 + 2 * n) / 100;
   endfunction : ref_exp
   task automatic step;
      @(posedge ref_clk_i);
      #1;
   endtask : step
   task automatic setp(input logic [15:0] v);
      @(posedge ref_clk_i);
      pressure <= v;
      #1;
   endtask : setp
   task automatic quiet(input int cyc);
      logic [2:0] prev;
      prev = pumps_on;
      repeat (cyc) step();
      check(pumps_on, prev, "pump count moved");
   endtask : quiet
   // time to next pump step; speed seen in the cycle before it
   task automatic wait_step(input int dir, input int lo, input int hi, input logic ov_chk);
      int         cnt;
      logic [2:0] prev;
      logic [7:0] sp;
      logic       ov;
      prev = pumps_on;
      sp = speed;
      ov = ovr;
      cnt = 0;
      while (pumps_on === prev && cnt < hi)
      begin
         sp = speed;
         ov = ovr;
         step();
         cnt++;
      end
      if (cnt >= hi)
      begin
         check(0, 1, "no pump step in time");
         end_sim();
      end
      n_exp += dir;
      check(pumps_on, n_exp, "pump count");
      check(relay, (1 << n_exp) - 1, "relay pattern");
      check(cnt >= lo, 1, "step too early");
      check(sp, (dir > 0) ? hand : 8'h64, "transition speed");
      check(ov, ov_chk, "speed override pulse");
      repeat (2) step();
      check(refo, ref_exp(n_exp), "scaled reference");
      check(running, n_exp, "running pumps");
   endtask : wait_step
   // glitch shorter than the delay, then a full run up to the limit or down to zero pumps
   task automatic run_dir(input int dir, input logic [15:0] mild);
      int tgt;
      d = (dir > 0) ? st_dly : ds_dly;
      tgt = (dir > 0) ? lim : 0;
      setp(mild);
      repeat ((d - 1) * T - 5) step();
      setp(16'h0f96 + 16'($urandom % 510));
      repeat (20) step();
      check(pumps_on, n_exp, "glitch changed pumps");
      setp(mild);
      while (n_exp != tgt)
         wait_step(dir, (d - 1) * T, d * T + 10, trip == 1'b0);
      quiet((d + 2) * T);
      setp(16'h1068);
   endtask : run_dir
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      k = $urandom(32'h1f3d);
      repeat (16) @(posedge ref_clk_i);
      #1;
      check({relay, pumps_on, speed, ovr}, {4'h0, 3'h0, 8'h64, 1'b0}, "outputs in reset");
      check(refo, 16'h0000, "reference in reset");
      @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      fb_max <= 16'h0800;
      repeat (6) step();
      check(refo, 16'h0800, "setpoint upper clamp");
      @(posedge ref_clk_i);
      fb_max <= 16'hffff;
      fb_min <= 16'h2000;
      repeat (6) step();
      check(refo, 16'h2000, "setpoint lower clamp");
      @(posedge ref_clk_i);
      fb_min <= 16'h0000;
      lim = 2 + $urandom % 3;
      pcount <= 3'(lim);
      st_dly <= 12'(2 + $urandom % 3);
      ds_dly <= 12'(2 + $urandom % 3);
      repeat (6) step();
      check(refo, SP, "setpoint passes");
      run_dir(1, 16'h0dde + 16'($urandom % 130));
      repeat (8)
      begin
         setp(16'h0f96 + 16'($urandom % 510));
         quiet(30);
      end
      @(posedge ref_clk_i);
      trip <= 1'b1;
      run_dir(-1, 16'h1306 + 16'($urandom % 40));
      @(posedge ref_clk_i);
      trip <= 1'b0;
      st_dly <= 12'hbb8;
      ds_dly <= 12'hbb8;
      lock <= 12'h003;
      override_band_pct <= 8'h14;
      repeat (40) step();
      for (int dir = 1; dir >= -1; dir -= 2)
      begin
         setp((dir > 0) ? 16'h03e8 : 16'h2328);
         wait_step(dir, 0, 15, 1'b1);
         wait_step(dir, 2 * T, 3 * T + 10, 1'b1);
         setp(16'h1068);
         repeat (40) step();
      end
      @(posedge ref_clk_i);
      override_band_pct <= 8'h64;
      setp(16'h03e8);
      quiet(100);
      @(posedge ref_clk_i);
      override_band_pct <= 8'h14;
      wait_step(1, 0, 15, 1'b1);
      @(posedge ref_clk_i);
      resetn_i <= 1'b0;
      pressure <= 16'h1068;
      step();
      check({relay, pumps_on, speed}, {4'h0, 3'h0, 8'h64}, "mid-run reset");
      @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      setp(16'h1068);
      repeat (10) step();
      check(pumps_on, 3'h0, "pumps after reset");
      end_sim();
   end
endmodule : pump_staging_controller_tb_top
